// File: rtl/btob_core.sv
// The implementer's own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
module btob_core (
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  output logic      [20:0]  prog_addr,
  input  wire logic [15:0]  prog_data,
  output logic      [11:0]  dmem_addr,
  output logic              dmem_re,
  output logic              dmem_we,
  output logic      [7:0]   dmem_wdata,
  input  wire logic [7:0]   dmem_rdata,
  input  wire logic [3:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  input  wire logic [3:0]   avs_byteenable,
  output logic      [31:0]  avs_readdata,
  output logic              avs_waitrequest
);

  btob_pkg::btob_phase_type phase_reg;
  btob_pkg::btob_class_type dec_cls;
  btob_pkg::btob_class_type cls_reg;
  logic [15:0] dec_in;
  logic [2:0]  dec_bit;
  logic [11:0] dec_addr;
  logic [20:0] dec_disp;
  logic [15:0] ir_reg;
  logic [20:0] pc_reg;
  logic [20:0] pc_next;
  logic [20:0] br_target_reg;
  logic        branch_reg;
  logic        flush_reg;
  logic        kill_reg;
  logic [7:0]  data_reg;
  logic        run_reg;
  logic        ext_reg;
  logic        ovf_reg;
  logic [3:0]  bsr_reg;
  logic [11:0] idx_reg;
  logic        last_taken_reg;
  logic        last_skip_reg;
  logic [31:0] rd_mux;
  logic [31:0] ctrl_word;
  logic        acc_wr;
  logic        tbit;
  logic [31:0] pc_merge;
  logic [31:0] ctrl_merge;
  logic [31:0] idx_merge;

  function automatic logic [7:0] bit_mask(input logic [2:0] b);
    return 8'h01 << b;
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // in q1 the fresh word from program memory is decoded, later the held one
  assign dec_in = (phase_reg == btob_pkg::PH_Q1) ? prog_data : ir_reg;

  btob_decode u_dec (
    .instr    (dec_in),
    .bank_select_reg      (bsr_reg),
    .ext_en   (ext_reg),
    .idx_base (idx_reg),
    .cls      (dec_cls),
    .bit_sel  (dec_bit),
    .daddr    (dec_addr),
    .br_disp  (dec_disp)
  );

  assign tbit    = (data_reg & bit_mask(dec_bit)) != 8'h00;
  assign pc_next = branch_reg ? br_target_reg : pc_reg;
  assign acc_wr  = avs_write && !avs_waitrequest;
  assign ctrl_word = {16'h0000, 4'h0, bsr_reg, 5'h00, ovf_reg, ext_reg, run_reg};

  // byte-enable merge of a software write into each register's current value
  assign pc_merge   = be_merge({11'h000, pc_reg}, avs_writedata, avs_byteenable);
  assign ctrl_merge = be_merge(ctrl_word, avs_writedata, avs_byteenable);
  assign idx_merge  = be_merge({20'h00000, idx_reg}, avs_writedata, avs_byteenable);

  // quarter phase sequencer, frozen while stopped
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_reg <= btob_pkg::PH_Q1;
    end else if (run_reg) begin
      case (phase_reg)
        btob_pkg::PH_Q1: phase_reg <= btob_pkg::PH_Q2;
        btob_pkg::PH_Q2: phase_reg <= btob_pkg::PH_Q3;
        btob_pkg::PH_Q3: phase_reg <= btob_pkg::PH_Q4;
        btob_pkg::PH_Q4: phase_reg <= btob_pkg::PH_Q1;
        default:         phase_reg <= btob_pkg::PH_Q1;
      endcase
    end
  end

  // fetch and kill: a flushed slot runs as a no-operation
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ir_reg   <= 16'h0000;
      cls_reg  <= btob_pkg::CLS_NOP;
      kill_reg <= 1'b0;
    end else if (run_reg && phase_reg == btob_pkg::PH_Q1) begin
      ir_reg   <= prog_data;
      kill_reg <= flush_reg;
      cls_reg  <= flush_reg ? btob_pkg::CLS_NOP : dec_cls;
    end
  end

  // program counter: bumps in q1, written in q4; software write wins
  // the slot after a taken branch fetched the target and is killed, so the
  // count holds there and the target is fetched again in the next cycle
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pc_reg    <= btob_pkg::PC_RST;
      prog_addr <= btob_pkg::PC_RST;
    end else if (acc_wr && avs_address == btob_pkg::OFF_PC) begin
      pc_reg    <= pc_merge[20:0];
      prog_addr <= pc_merge[20:0];
    end else if (run_reg && phase_reg == btob_pkg::PH_Q1) begin
      pc_reg <= branch_reg ? pc_reg : pc_reg + btob_pkg::PC_STEP;
    end else if (run_reg && phase_reg == btob_pkg::PH_Q4) begin
      pc_reg    <= pc_next;
      prog_addr <= pc_next;
    end
  end

  // data memory read strobe in q2, capture at its end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dmem_addr <= 12'h000;
      dmem_re   <= 1'b0;
      data_reg  <= 8'h00;
    end else if (run_reg) begin
      if (phase_reg == btob_pkg::PH_Q1) begin
        dmem_addr <= dec_addr;
        dmem_re   <= !flush_reg && (dec_cls == btob_pkg::CLS_INV ||
                     dec_cls == btob_pkg::CLS_TSC || dec_cls == btob_pkg::CLS_TSS);
      end else if (phase_reg == btob_pkg::PH_Q2) begin
        dmem_re  <= 1'b0;
        data_reg <= dmem_rdata;
      end
    end
  end

  // q3 processing: invert write-back, skip decision, branch target
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dmem_we        <= 1'b0;
      dmem_wdata     <= 8'h00;
      branch_reg     <= 1'b0;
      br_target_reg  <= btob_pkg::PC_RST;
      flush_reg      <= 1'b0;
      last_taken_reg <= 1'b0;
      last_skip_reg  <= 1'b0;
    end else if (run_reg) begin
      case (phase_reg)
        btob_pkg::PH_Q1: begin
          flush_reg  <= 1'b0;
          branch_reg <= 1'b0;
        end
        btob_pkg::PH_Q3: begin
          case (cls_reg)
            btob_pkg::CLS_INV: begin
              dmem_wdata <= data_reg ^ bit_mask(dec_bit);
              dmem_we    <= 1'b1;
            end
            btob_pkg::CLS_BOV: begin
              br_target_reg  <= pc_reg + dec_disp;
              branch_reg     <= ovf_reg;
              flush_reg      <= ovf_reg;
              last_taken_reg <= ovf_reg;
            end
            btob_pkg::CLS_TSC: begin
              flush_reg     <= !tbit;
              last_skip_reg <= !tbit;
            end
            btob_pkg::CLS_TSS: begin
              flush_reg     <= tbit;
              last_skip_reg <= tbit;
            end
            default: begin
              flush_reg <= 1'b0;
            end
          endcase
        end
        btob_pkg::PH_Q4: begin
          dmem_we <= 1'b0;
        end
        default: begin
          dmem_we <= 1'b0;
        end
      endcase
    end else begin
      dmem_we <= 1'b0;
    end
  end

  // software control bits; the core itself never alters the flag
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_reg <= 1'b0;
      ext_reg <= 1'b0;
      ovf_reg <= 1'b0;
      bsr_reg <= btob_pkg::BSR_RST;
      idx_reg <= btob_pkg::IDX_RST;
    end else if (acc_wr) begin
      if (avs_address == btob_pkg::OFF_CTRL) begin
        run_reg <= ctrl_merge[btob_pkg::CTRL_RUN];
        ext_reg <= ctrl_merge[btob_pkg::CTRL_EXT];
        ovf_reg <= ctrl_merge[btob_pkg::CTRL_OVF];
        bsr_reg <= ctrl_merge[btob_pkg::CTRL_BSR_MSB:btob_pkg::CTRL_BSR_LSB];
      end else if (avs_address == btob_pkg::OFF_IDX) begin
        idx_reg <= idx_merge[11:0];
      end
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    case (avs_address)
      btob_pkg::OFF_CTRL: rd_mux = ctrl_word;
      btob_pkg::OFF_PC:   rd_mux = {11'h000, pc_reg};
      btob_pkg::OFF_IDX:  rd_mux = {20'h00000, idx_reg};
      btob_pkg::OFF_STAT: rd_mux = {27'h0000000, last_skip_reg, last_taken_reg,
                                    kill_reg, phase_reg};
      default:            rd_mux = 32'h00000000;
    endcase
  end

  // one wait cycle per access keeps readdata a clean flop output
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= avs_read ? rd_mux : 32'h00000000;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

endmodule

// File: rtl/btob_pkg.sv
package btob_pkg;

  // register byte offsets on the avalon slave
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_PC   = 4'h4;
  localparam logic [3:0] OFF_IDX  = 4'h8;
  localparam logic [3:0] OFF_STAT = 4'hc;

  // control register field positions
  localparam int CTRL_RUN     = 0;
  localparam int CTRL_EXT     = 1;
  localparam int CTRL_OVF     = 2;
  localparam int CTRL_BSR_LSB = 8;
  localparam int CTRL_BSR_MSB = 11;

  // widths
  localparam int PC_W    = 21;
  localparam int DADDR_W = 12;

  // reset values and program counter step
  localparam logic [20:0] PC_RST   = 21'h000000;
  localparam logic [11:0] IDX_RST  = 12'h000;
  localparam logic [3:0]  BSR_RST  = 4'h0;
  localparam logic [20:0] PC_STEP  = 21'h000002;

  // opcode fields
  localparam logic [3:0] OP_INV_HI = 4'h7;
  localparam logic [3:0] OP_TSC_HI = 4'hb;
  localparam logic [3:0] OP_TSS_HI = 4'ha;
  localparam logic [7:0] OP_BOV_HI = 8'he4;

  // access bank and indexed literal offset limits
  localparam logic [7:0] IDX_LIMIT   = 8'h5f;
  localparam logic [7:0] ACC_SPLIT   = 8'h80;
  localparam logic [3:0] ACC_LO_BANK = 4'h0;
  localparam logic [3:0] ACC_HI_BANK = 4'hf;

  // quarter phases, gray coded along the cycle
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b11,
    PH_Q4 = 2'b10
  } btob_phase_type;

  typedef enum logic [2:0] {
    CLS_NOP = 3'h0,
    CLS_INV = 3'h1,
    CLS_BOV = 3'h2,
    CLS_TSC = 3'h3,
    CLS_TSS = 3'h4
  } btob_class_type;

endpackage

// File: rtl/btob_decode.sv
`timescale 1ns/1ps
module btob_decode (
  input  wire logic [15:0]            instr,
  input  wire logic [3:0]             bank_select_reg,
  input  wire logic                   ext_en,
  input  wire logic [11:0]            idx_base,
  output btob_pkg::btob_class_type    cls,
  output logic      [2:0]             bit_sel,
  output logic      [11:0]            daddr,
  output logic      [20:0]            br_disp
);

  logic [7:0] fld;
  logic       acc;

  assign fld     = instr[7:0];
  assign acc     = instr[8];
  assign bit_sel = instr[11:9];
  // doubled signed offset, sign carried up to pc width
  assign br_disp = {{12{instr[7]}}, instr[7:0], 1'b0};

  // opcode class
  always_comb begin
    cls = btob_pkg::CLS_NOP;
    if (instr[15:8] == btob_pkg::OP_BOV_HI) begin
      cls = btob_pkg::CLS_BOV;
    end else begin
      case (instr[15:12])
        btob_pkg::OP_INV_HI: cls = btob_pkg::CLS_INV;
        btob_pkg::OP_TSC_HI: cls = btob_pkg::CLS_TSC;
        btob_pkg::OP_TSS_HI: cls = btob_pkg::CLS_TSS;
        default:             cls = btob_pkg::CLS_NOP;
      endcase
    end
  end

  // data address: banked, access bank, or indexed literal offset
  always_comb begin
    if (acc) begin
      daddr = {bank_select_reg, fld};
    end else if (ext_en && (fld <= btob_pkg::IDX_LIMIT)) begin
      daddr = idx_base + {4'h0, fld};
    end else if (fld < btob_pkg::ACC_SPLIT) begin
      daddr = {btob_pkg::ACC_LO_BANK, fld};
    end else begin
      daddr = {btob_pkg::ACC_HI_BANK, fld};
    end
  end

endmodule

// File: verif/btob_checker.sv
`timescale 1ns/1ps
module btob_checker (
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic [20:0] prog_addr,
  input wire logic [11:0] dmem_addr,
  input wire logic        dmem_re,
  input wire logic        dmem_we,
  input wire logic [7:0]  dmem_wdata,
  input wire logic [7:0]  dmem_rdata,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // bus answers exactly one cycle after a request is seen, never unasked
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered in one cycle");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  wait_idle_a: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest dropped with no request");

  // write-back follows the read of the same byte two cycles later
  we_after_read_a: assert property (dmem_we |-> $past(dmem_re, 2))
    else $error("write-back without read two cycles before");
  we_spacing_a: assert property (dmem_we |=> !dmem_we [*3])
    else $error("write-back strobes closer than one instruction");
  re_spacing_a: assert property (dmem_re |=> !dmem_re [*3])
    else $error("read strobes closer than one instruction");
  same_addr_a: assert property (dmem_we |-> dmem_addr == $past(dmem_addr, 2))
    else $error("write-back address differs from read address");
  one_bit_a: assert property (dmem_we |-> $countones(dmem_wdata ^ $past(dmem_rdata, 2)) == 1)
    else $error("write-back does not differ in exactly one bit");

  // fetch address moves once per instruction unless software wrote it
  pc_hold_a: assert property ($changed(prog_addr) && !$past(avs_write) |=>
    ($past(avs_write) || $stable(prog_addr)) [*3])
    else $error("fetch address moved inside an instruction cycle");
endmodule

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        ref_clk, sys_rst, dmem_re, dmem_we, avs_read, avs_write, avs_waitrequest;
  logic [20:0] prog_addr;
  logic [15:0] prog_data;
  logic [11:0] dmem_addr;
  logic [7:0]  dmem_wdata, dmem_rdata;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [15:0] pmem [256];
  logic [7:0]  dmem [4096];
  int          err_total, samples_checked;

  btob_core u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .prog_addr(prog_addr),
    .prog_data(prog_data), .dmem_addr(dmem_addr), .dmem_re(dmem_re), .dmem_we(dmem_we),
    .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  // memories answer combinationally; program wraps at 256 words
  assign prog_data  = pmem[prog_addr[8:1]];
  assign dmem_rdata = dmem[dmem_addr];
  always @(posedge ref_clk) if (dmem_we) dmem[dmem_addr] <= dmem_wdata;

  initial begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check32(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one avalon transfer; idle cycle after it so strobes never re-assert in one step
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_read       <= ~wr;
    avs_write      <= wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 20);
    if (n >= 20) err_total++;
    rd = avs_readdata;
    avs_read  <= 1'h0;
    avs_write <= 1'h0;
    @(posedge ref_clk);
  endtask

  // reset first: stopping run freezes mid-cycle, so each program starts clean at q1
  task automatic run(input logic ovf, input logic ext, input logic [3:0] bank_select_reg,
                     input logic [11:0] idx, input int k);
    sys_rst <= 1'h1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'h0;
    @(posedge ref_clk);
    bus(1'h1, btob_pkg::OFF_PC, 32'h0000_0100, 4'hf);
    bus(1'h1, btob_pkg::OFF_IDX, {20'h0, idx}, 4'hf);
    bus(1'h1, btob_pkg::OFF_CTRL, {20'h0, bank_select_reg, 5'h0, ovf, ext, 1'h1}, 4'hf);
    repeat (k * 4) @(posedge ref_clk);
    bus(1'h1, btob_pkg::OFF_CTRL, 32'h0, 4'hf);
  endtask

  function automatic logic [11:0] ea(logic a, logic [7:0] f, logic ext, logic [3:0] bank_select_reg,
                                     logic [11:0] idx);
    if (a) return {bank_select_reg, f};
    if (ext && f <= 8'h5f) return idx + {4'h0, f};
    return (f < 8'h80) ? {4'h0, f} : {4'hf, f};
  endfunction

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // watchdog well above the roughly 860 cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    end_of_test();
  end

  initial begin
    logic        a, ext, ovf, set, bv;
    logic [2:0]  b;
    logic [3:0]  bank_select_reg;
    logic [7:0]  f, v, n, tw;
    logic [11:0] idx, ad;
    sys_rst = 1'h1;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    void'($urandom(44338));
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'h0;
    @(posedge ref_clk);
    bus(1'h0, btob_pkg::OFF_PC, 32'h0, 4'hf);
    check32("pc reset", 32'h0, rd);
    bus(1'h0, btob_pkg::OFF_CTRL, 32'h0, 4'hf);
    check32("ctrl reset", 32'h0, rd);
    bus(1'h1, btob_pkg::OFF_IDX, 32'hffff_fabc, 4'hf);
    bus(1'h1, btob_pkg::OFF_IDX, 32'h0000_0f55, 4'h1);
    bus(1'h0, btob_pkg::OFF_IDX, 32'h0, 4'hf);
    check32("index base", 32'h0000_0a55, rd);
    bus(1'h0, 4'h6, 32'h0, 4'hf);
    check32("unmapped read", 32'h0, rd);
    $display("test registers done");
    for (int i = 0; i < 10; i++) begin
      {a, b, f, ext, bank_select_reg, idx} = {$urandom, $urandom};
      if (i < 2) {a, ext, f} = {2'h1, 8'(8'h5f + i)}; // index window edge
      foreach (pmem[j]) pmem[j] = 16'h0;
      pmem[128] = {btob_pkg::OP_INV_HI, b, a, f};
      ad = ea(a, f, ext, bank_select_reg, idx);
      v = $urandom;
      dmem[ad] = v;
      run(1'h0, ext, bank_select_reg, idx, 3);
      check8("inverted byte", v ^ (8'h01 << b), dmem[ad]);
    end
    $display("test invert done");
    for (int k = 0; k < 4; k++) begin
      {set, bv, b, f, bank_select_reg, v} = {1'(k / 2), 1'(k % 2), 23'($urandom)};
      v[b] = bv;
      foreach (pmem[j]) pmem[j] = 16'h0;
      pmem[128] = {set ? btob_pkg::OP_TSS_HI : btob_pkg::OP_TSC_HI, b, 1'h1, f};
      pmem[129] = {btob_pkg::OP_INV_HI, 3'h0, 1'h1, 8'(f + 8'h1)};
      pmem[130] = {btob_pkg::OP_INV_HI, 3'h1, 1'h1, 8'(f + 8'h2)};
      {dmem[{bank_select_reg, f}], dmem[{bank_select_reg, 8'(f + 8'h1)}], dmem[{bank_select_reg, 8'(f + 8'h2)}]} = {v, 16'h0};
      run(1'h0, 1'h0, bank_select_reg, 12'h0, 5);
      check8("skipped slot", (set == bv) ? 8'h00 : 8'h01, dmem[{bank_select_reg, 8'(f + 8'h1)}]);
      check8("after skip", 8'h02, dmem[{bank_select_reg, 8'(f + 8'h2)}]);
      check8("tested byte", v, dmem[{bank_select_reg, f}]);
      bus(1'h0, btob_pkg::OFF_STAT, 32'h0, 4'hf);
      check32("skip status", (set == bv) ? 32'h12 : 32'h02, rd);
    end
    $display("test skip done");
    for (int i = 0; i < 10; i++) begin
      ovf = 1'(i % 2);
      n = ($urandom % 2) ? 8'($urandom_range(100, 8)) : 8'(0 - int'($urandom_range(100, 3)));
      if (i < 2) n = 8'h80; // most negative offset
      tw = 8'(8'h81 + n);
      foreach (pmem[j]) pmem[j] = 16'h0;
      pmem[128] = {btob_pkg::OP_BOV_HI, n};
      pmem[129] = {btob_pkg::OP_INV_HI, 3'h2, 1'h1, 8'h10};
      pmem[tw] = {btob_pkg::OP_INV_HI, 3'h3, 1'h1, 8'h11};
      pmem[8'(tw + 8'h1)] = {btob_pkg::OP_BOV_HI, 8'h7f}; // escape forward
      {dmem[12'h110], dmem[12'h111]} = 16'h0;
      run(ovf, 1'h0, 4'h1, 12'h0, 6);
      check8("fall-through slot", ovf ? 8'h00 : 8'h04, dmem[12'h110]);
      check8("branch target", ovf ? 8'h08 : 8'h00, dmem[12'h111]);
      bus(1'h0, btob_pkg::OFF_STAT, 32'h0, 4'hf);
      check32("branch status", ovf ? 32'h0a : 32'h02, rd);
    end
    $display("test branch done");
    end_of_test();
  end
endmodule

bind btob_core btob_checker u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .prog_addr(prog_addr), .dmem_addr(dmem_addr), .dmem_re(dmem_re), .dmem_we(dmem_we),
  .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest));
